// ===== cgs_pkg.sv
// constants shared by the cic gain/shift control block and its fifo
// assumes a single 25 mhz clock domain and a plain register port
package cgs_pkg;
   // register map, byte offsets on the plain register port
   localparam logic [3:0] CFG0_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [31:0] CFG0_RST = 32'h0000_0000;
   // configuration word 0 field positions
   localparam int BYPASS_BIT = 6;
   localparam int DEC_LSB = 7;
   localparam int DEC_W = 6;
   localparam int SG_LSB = 13;
   localparam int SG_W = 4;
   localparam int XSYNC_BIT = 19;
   // status word field positions
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_LVL_LSB = 8;
   // datapath shape
   localparam int IN_W = 15;
   localparam int CODE_W = 3;
   localparam int N_STAGES = 5;
   localparam int ACC_MAX_W = 40;
   localparam int ACC_W [N_STAGES] = '{40, 36, 32, 32, 32};
   localparam int OUT_W = 32;
   localparam logic [SG_W-1:0] SHIFT_MAX = 4'hF;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_INFLIGHT = 3;
endpackage

// ===== cgs_fifo.sv
// synchronous fifo with valid/ready on both sides and a fill level
// assumes one clock; write and read may happen in the same cycle
`timescale 1ns/1ps
`default_nettype none
module cgs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q, rd_ptr_q;
   logic [LW-1:0] cnt_q;
   logic push, pop;

   // full and empty come straight from the count
   assign in_ready = (cnt_q != LW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign level = cnt_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage, no reset needed on the data words
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   // fill level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_q <= '0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // cgs_fifo
`default_nettype wire

// ===== cgs_cic.sv
// fifth order cic decimator front end: gain shift, decimation control, sync
// assumes mixer samples and gain offset code arrive together on one clock
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cgs_cic #(
   parameter int FIFO_DEPTH = cgs_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic mix_valid,
   output logic mix_ready,
   input wire logic signed [cgs_pkg::IN_W-1:0] mix_data,
   input wire logic [cgs_pkg::CODE_W-1:0] front_gain_offset_code,
   input wire logic multi_chip_sync_in,
   output logic out_valid,
   input wire logic out_ready,
   output logic [cgs_pkg::OUT_W-1:0] out_data
);
   localparam int AW = cgs_pkg::ACC_MAX_W;
   localparam int OW = cgs_pkg::OUT_W;
   localparam int LW = $clog2(FIFO_DEPTH+1);

   logic [31:0] cfg0_q;
   logic [31:0] rdata_q;
   logic bypass;
   logic xsync_en;
   logic [cgs_pkg::DEC_W-1:0] dec_m1;
   logic [cgs_pkg::SG_W-1:0] shift_gain;
   logic accept;
   logic v1_q;
   logic signed [cgs_pkg::IN_W-1:0] smp1_q;
   logic [cgs_pkg::CODE_W-1:0] code1_q;
   logic [cgs_pkg::SG_W:0] shift_sum;
   logic [cgs_pkg::SG_W-1:0] shift_amt;
   logic signed [AW-1:0] shifted;
   logic signed [AW-1:0] acc_q [cgs_pkg::N_STAGES];
   logic [cgs_pkg::DEC_W-1:0] dcnt_q;
   logic tick_q;
   logic byp_v_q;
   logic signed [OW-1:0] byp_q;
   logic signed [OW-1:0] cmb_in [cgs_pkg::N_STAGES+1];
   logic signed [OW-1:0] cmb_dly_q [cgs_pkg::N_STAGES];
   logic push;
   logic [OW-1:0] push_data;
   logic [LW-1:0] level;

   // configuration word 0 fields
   assign bypass = cfg0_q[cgs_pkg::BYPASS_BIT];
   assign dec_m1 = cfg0_q[cgs_pkg::DEC_LSB +: cgs_pkg::DEC_W];
   assign shift_gain = cfg0_q[cgs_pkg::SG_LSB +: cgs_pkg::SG_W];
   assign xsync_en = cfg0_q[cgs_pkg::XSYNC_BIT];

   // register writes; every bit of word 0 is stored so software reads it back
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg0_q <= cgs_pkg::CFG0_RST;
      end else if (reg_wr && reg_addr == cgs_pkg::CFG0_OFS) begin
         cfg0_q <= reg_wdata;
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            cgs_pkg::CFG0_OFS: rdata_q <= cfg0_q;
            cgs_pkg::STAT_OFS: rdata_q <= (32'(dcnt_q) << cgs_pkg::STAT_CNT_LSB)
                                        | (32'(level) << cgs_pkg::STAT_LVL_LSB);
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end
   assign reg_rdata = rdata_q;

   // hold off input while the fifo lacks room for samples still in flight
   assign mix_ready = (level <= LW'(FIFO_DEPTH - cgs_pkg::FIFO_INFLIGHT));
   assign accept = mix_valid && mix_ready;

   // sample and its gain code are captured in the same stage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         v1_q <= 1'b0;
         smp1_q <= '0;
         code1_q <= '0;
      end else begin
         v1_q <= accept;
         if (accept) begin
            smp1_q <= mix_data;
            code1_q <= front_gain_offset_code;
         end
      end
   end

   // saturating sum of programmed gain and pin code; 6dB per step
   assign shift_sum = {1'b0, shift_gain} + {2'b00, code1_q};
   assign shift_amt = shift_sum[cgs_pkg::SG_W] ? cgs_pkg::SHIFT_MAX
                                              : shift_sum[cgs_pkg::SG_W-1:0];
   // overflow from large offsets is the controller's to avoid, not clipped here
   assign shifted = AW'(smp1_q) <<< shift_amt;

   // integrator chain, each stage keeps the top bits of the one before
   for (genvar i = 0; i < cgs_pkg::N_STAGES; i++) begin : g_int
      localparam int W = cgs_pkg::ACC_W[i];
      logic signed [W-1:0] din;
      logic signed [W-1:0] sum;
      if (i == 0) begin : g_first
         assign din = shifted[W-1:0];
      end else begin : g_next
         localparam int PW = cgs_pkg::ACC_W[i-1];
         assign din = acc_q[i-1][PW-1 -: W];
      end
      assign sum = acc_q[i][W-1:0] + din; // wraps at width W
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            acc_q[i] <= '0;
         end else if (v1_q) begin
            acc_q[i] <= AW'(sum);
         end
      end
   end

   // decimation counter; the sync input reloads it for phase alignment
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dcnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= v1_q && (dcnt_q == '0) && !bypass;
         if (xsync_en && multi_chip_sync_in) begin
            dcnt_q <= dec_m1;
         end else if (v1_q) begin
            dcnt_q <= (dcnt_q == '0) ? dec_m1 : dcnt_q - 1'b1;
         end
      end
   end

   // bypass sends the unfiltered mixer sample straight on
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         byp_v_q <= 1'b0;
         byp_q <= '0;
      end else begin
         byp_v_q <= v1_q && bypass;
         byp_q <= OW'(smp1_q);
      end
   end

   // comb chain works on the last integrator, once per decimation period
   assign cmb_in[0] = acc_q[cgs_pkg::N_STAGES-1][OW-1:0];
   for (genvar k = 0; k < cgs_pkg::N_STAGES; k++) begin : g_cmb
      assign cmb_in[k+1] = cmb_in[k] - cmb_dly_q[k];
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            cmb_dly_q[k] <= '0;
         end else if (tick_q) begin
            cmb_dly_q[k] <= cmb_in[k];
         end
      end
   end

   assign push = tick_q || byp_v_q;
   assign push_data = byp_v_q ? byp_q : cmb_in[cgs_pkg::N_STAGES];

   // output buffer toward the halfband stages
   cgs_fifo #(.WIDTH(OW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(push),
      .in_ready(),
      .in_data(push_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data),
      .level(level)
   );

   // checks on the gain and decimation control
   chk_shift_sat: assert property (@(posedge sys_clk) disable iff (srst)
      v1_q |-> (shift_amt == ((32'(shift_gain) + 32'(code1_q) > 15) ? 4'hF
                : 4'(shift_gain + 4'(code1_q)))))
      else $error("shift amount not saturating sum");
   chk_code_pipe: assert property (@(posedge sys_clk) disable iff (srst)
      accept |=> (code1_q == $past(front_gain_offset_code) && smp1_q == $past(mix_data)))
      else $error("gain code not paired with its sample");
   chk_offset_step: assert property (@(posedge sys_clk) disable iff (srst)
      (v1_q && shift_gain == 4'h0) |-> (shifted == (AW'(smp1_q) <<< code1_q)))
      else $error("offset code step is not one bit");
   chk_field_write: assert property (@(posedge sys_clk) disable iff (srst)
      (reg_wr && reg_addr == cgs_pkg::CFG0_OFS) |=>
      (dec_m1 == $past(reg_wdata[12:7]) && shift_gain == $past(reg_wdata[16:13])
       && bypass == $past(reg_wdata[6])))
      else $error("word 0 fields misplaced");
   chk_sync_reload: assert property (@(posedge sys_clk) disable iff (srst)
      (xsync_en && multi_chip_sync_in) |=> (dcnt_q == $past(dec_m1)))
      else $error("sync did not reload decimation counter");
   chk_tick_period: assert property (@(posedge sys_clk) disable iff (srst)
      (v1_q && dcnt_q == 6'h00 && !bypass && !(xsync_en && multi_chip_sync_in))
      |=> (tick_q && dcnt_q == $past(dec_m1)))
      else $error("decimation period wrong");
   chk_no_tick_mid: assert property (@(posedge sys_clk) disable iff (srst)
      (v1_q && dcnt_q != 6'h00) |=> !tick_q)
      else $error("comb ran mid period");
   chk_integ_wrap: assert property (@(posedge sys_clk) disable iff (srst)
      v1_q |=> (acc_q[0] == $past(acc_q[0]) + $past(shifted)))
      else $error("first integrator not wrapping sum");
   chk_bypass_path: assert property (@(posedge sys_clk) disable iff (srst)
      (v1_q && bypass) |=> (push && push_data == OW'($past(smp1_q)) && !tick_q))
      else $error("bypass sample lost");
   cov_sync: cover property (@(posedge sys_clk) xsync_en && multi_chip_sync_in && v1_q);
   cov_sat: cover property (@(posedge sys_clk) v1_q && shift_sum > 5'h0F);
   cov_tick: cover property (@(posedge sys_clk) tick_q && dec_m1 == 6'h1F);
   cov_stall: cover property (@(posedge sys_clk) mix_valid && !mix_ready);
endmodule // cgs_cic
`default_nettype wire

// ===== cgs_mix_src.sv
// mixer and receiver gain-control model: samples, offset code, sync pulse
// assumes the block samples on the rising edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module cgs_mix_src (
   input wire logic sys_clk,
   input wire logic mix_ready,
   output logic mix_valid,
   output logic signed [14:0] mix_data,
   output logic [2:0] front_gain_offset_code,
   output logic multi_chip_sync_in
);
   logic rdy;
   // idle levels at time zero
   initial begin
      mix_valid = 1'b0;
      mix_data = 15'h0;
      front_gain_offset_code = 3'h0;
      multi_chip_sync_in = 1'b0;
   end
   // offered sample stays put until mix_ready is seen at an edge
   task automatic send(input int n, input logic [14:0] x, input logic [2:0] c);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         mix_valid <= 1'b1;
         mix_data <= x;
         front_gain_offset_code <= c;
         do begin
            @(negedge sys_clk);
            rdy = mix_ready;
         end while (rdy !== 1'b1);
      end
      @(posedge sys_clk);
      mix_valid <= 1'b0;
      mix_data <= ~x; // stale data is never left on the bus
   endtask
   // one-cycle sync pulse
   task automatic pulse();
      @(posedge sys_clk);
      multi_chip_sync_in <= 1'b1;
      @(posedge sys_clk);
      multi_chip_sync_in <= 1'b0;
   endtask
endmodule // cgs_mix_src
`default_nettype wire

// ===== tb.sv
// self-checking bench for the cic gain/shift control block
// assumes the mixer model drives the sample side
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk, srst, reg_wr, reg_rd, mix_valid, mix_ready, sync_in, out_valid, out_ready;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, out_data, last, v;
   logic signed [14:0] mix_data;
   logic [2:0] code;
   int error_cnt, checked, pops;
   cgs_cic dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mix_valid(mix_valid),
      .mix_ready(mix_ready), .mix_data(mix_data), .front_gain_offset_code(code),
      .multi_chip_sync_in(sync_in), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data));
   cgs_mix_src src (.sys_clk(sys_clk), .mix_ready(mix_ready), .mix_valid(mix_valid),
      .mix_data(mix_data), .front_gain_offset_code(code), .multi_chip_sync_in(sync_in));
   // 25 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // count popped words, keep the latest; the count clears with the block's reset
   always @(posedge sys_clk) begin
      if (srst) begin
         pops <= 0;
      end else if (out_valid && out_ready) begin
         pops <= pops + 1;
         last <= out_data;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic logic [31:0] cfg(int dec, int sg, bit byp, bit xs);
      return (32'(xs) << cgs_pkg::XSYNC_BIT) | (32'(sg) << cgs_pkg::SG_LSB) |
         (32'(dec) << cgs_pkg::DEC_LSB) | (32'(byp) << cgs_pkg::BYPASS_BIT);
   endfunction
   task automatic do_rst();
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] ad, output logic [31:0] d);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic wait_pops(input int n);
      repeat (80) if (pops != n) @(posedge sys_clk);
   endtask
   // reset value, field readback, unmapped and read-only places
   task automatic t_regs();
      do_rst();
      rd(cgs_pkg::CFG0_OFS, v);
      chk(v, cgs_pkg::CFG0_RST);
      wr(cgs_pkg::CFG0_OFS, cfg(63, 15, 1, 1));
      wr(cgs_pkg::STAT_OFS, 32'hFFFF_FFFF);
      rd(cgs_pkg::CFG0_OFS, v);
      chk(v, cfg(63, 15, 1, 1));
      rd(cgs_pkg::STAT_OFS, v);
      chk(v, 32'h0000_0000);
      rd(4'h8, v);
      chk(v, 32'h0000_0000);
      $display("regs done");
   endtask
   // one output per R samples, shift gain from the 14-bit formula
   task automatic t_decim();
      // 14, 12, 10 and 8 bit inputs at the top of their decimation ranges
      int rs[6] = '{1, 4, 32, 40, 52, 64};
      int sgs[6] = '{15, 15, 0, 0, 0, 1};
      foreach (rs[i]) begin
         do_rst();
         wr(cgs_pkg::CFG0_OFS, cfg(rs[i] - 1, sgs[i], 0, 0));
         src.send(rs[i] * 3, 15'h0040, 3'h0);
         wait_pops(3);
         chk(pops, 3);
      end
      $display("decim done");
   endtask
   // bypass routes each sample straight out, sign-extended
   task automatic t_bypass();
      do_rst();
      wr(cgs_pkg::CFG0_OFS, cfg(7, 0, 1, 0));
      src.send(3, 15'h7FFB, 3'h0);
      wait_pops(3);
      chk(pops, 3);
      chk(last, 32'hFFFF_FFFB);
      $display("bypass done");
   endtask
   // sync reloads the counter only when enabled
   task automatic t_sync();
      do_rst();
      wr(cgs_pkg::CFG0_OFS, cfg(9, 0, 0, 0));
      src.pulse();
      rd(cgs_pkg::STAT_OFS, v);
      chk(v[5:0], 6'h00);
      wr(cgs_pkg::CFG0_OFS, cfg(9, 0, 0, 1));
      src.pulse();
      rd(cgs_pkg::STAT_OFS, v);
      chk(v[5:0], 6'h09);
      $display("sync done");
   endtask
   task automatic dc(input int sg, input logic [2:0] c, output logic [31:0] r);
      do_rst();
      wr(cgs_pkg::CFG0_OFS, cfg(0, sg, 0, 0));
      src.send(8, 15'h1000, c);
      wait_pops(8);
      r = last;
   endtask
   // shift is gain plus offset code, saturating at 15
   // unity cic at R=1 with 8 pruned lsbs: settled output is (0x1000 << shift) >> 8
   task automatic t_sat();
      dc(15, 3'h0, v);
      chk(v, 32'h0008_0000);
      dc(12, 3'h3, v);
      chk(v, 32'h0008_0000);
      dc(15, 3'h7, v);
      chk(v, 32'h0008_0000);
      dc(0, 3'h0, v);
      chk(v, 32'h0000_0010);
      dc(0, 3'h1, v);
      chk(v, 32'h0000_0020);
      $display("sat done");
   endtask
   // fill until refused with the far end stalled, then drain
   task automatic t_fifo();
      do_rst();
      wr(cgs_pkg::CFG0_OFS, cfg(0, 0, 1, 0));
      out_ready <= 1'b0;
      fork
         src.send(20, 15'h0011, 3'h0);
      join_none
      repeat (40) @(posedge sys_clk);
      rd(cgs_pkg::STAT_OFS, v);
      chk(32'(v[12:8]), 32'(cgs_pkg::FIFO_DEPTH));
      @(negedge sys_clk);
      chk(mix_ready, 1'b0);
      chk(out_valid, 1'b1);
      // release the far end on a rising edge, as every other input
      @(posedge sys_clk);
      out_ready <= 1'b1;
      wait fork;
      wait_pops(20);
      chk(pops, 20);
      $display("fifo done");
   endtask
   // watchdog
   initial begin
      #2000000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      out_ready = 1'b1;
      repeat (2) @(posedge sys_clk);
      t_regs();
      t_decim();
      t_bypass();
      t_sync();
      t_sat();
      t_fifo();
      wrap_up();
   end
endmodule // tb
`default_nettype wire
